// file: eaid_regs.svh
// register offsets, field positions and sizes of the event dispatcher
`ifndef EAID_REGS_SVH
`define EAID_REGS_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define EAID_OFS_CTRL 8'h00
`define EAID_OFS_ATTACH 8'h04
`define EAID_OFS_DETACH 8'h08
`define EAID_OFS_STATUS 8'h0C
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define EAID_GIE_BIT 0
`define EAID_EV_MSB 5
`define EAID_RT_LSB 8
`define EAID_RT_MSB 14
`define EAID_ST_ROUT_BIT 1
`define EAID_ST_SUB_BIT 2
`define EAID_ST_ERR_BIT 3
`define EAID_ST_OVF_LSB 4
`define EAID_ST_OVF_MSB 6
`define EAID_ST_EV_LSB 16
`define EAID_ST_EV_MSB 21
// ---------------------------------------------------------------
// sizes, group masks and bus answers
// ---------------------------------------------------------------
`define EAID_NUM_EV 34
`define EAID_LAST_EV 6'h21
`define EAID_COMM_DEPTH 8
`define EAID_IO_DEPTH 16
`define EAID_TIMED_DEPTH 8
`define EAID_COMM_MASK 34'h007800300
`define EAID_TIMED_MASK 34'h000600C00
`define EAID_RESP_OKAY 2'h0
`define EAID_RESP_SLVERR 2'h2
`endif

// file: eaid_pkg.sv
// types shared by the event dispatcher modules
package eaid_pkg;
  typedef logic [5:0] eaid_ev_t;
  typedef logic [6:0] eaid_rt_t;
  typedef enum logic [1:0] {ST_MAIN, ST_ROUTINE, ST_SUB} eaid_state_e;
endpackage

// file: eaid_q_if.sv
// push/pop carrier between the dispatcher and one event queue
`timescale 1ns/1ps
interface eaid_q_if;
  import eaid_pkg::*;
  logic push;
  logic pop;
  logic clear;
  eaid_ev_t din;
  eaid_ev_t dout;
  logic full;
  logic empty;
  logic ovf;
  modport q(input push, input pop, input clear, input din,
            output dout, output full, output empty, output ovf);
  modport ctl(output push, output pop, output clear, output din,
              input dout, input full, input empty, input ovf);
endinterface

// file: eaid_queue.sv
// first-come-first-served event number queue with sticky overflow
`timescale 1ns/1ps
module eaid_queue import eaid_pkg::*; #(
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // queue port
  eaid_q_if.q q
);
  localparam int AW = $clog2(DEPTH);
  eaid_ev_t mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic ovf_r;
  wire do_push = q.push && !q.full;
  wire do_pop = q.pop && !q.empty;
  // status; depth is a power of two so pointers wrap by themselves
  assign q.full = (cnt_r == (AW+1)'(DEPTH));
  assign q.empty = (cnt_r == '0);
  assign q.dout = mem[rp_r];
  assign q.ovf = ovf_r;
  // storage has no reset, only pointers, count and overflow do
  always_ff @(posedge clk_in) begin
    if (do_push) begin
      mem[wp_r] <= q.din;
    end
  end
  // pointers and count; a lost push sets overflow, set beats clear
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      ovf_r <= 1'h0;
    end else begin
      wp_r <= do_push ? wp_r + 1'h1 : wp_r;
      rp_r <= do_pop ? rp_r + 1'h1 : rp_r;
      cnt_r <= cnt_r + {{AW{1'h0}}, do_push} - {{AW{1'h0}}, do_pop};
      ovf_r <= (q.push && q.full) || (ovf_r && !q.clear);
    end
  end
endmodule

// file: eaid_top.sv
// event attach table, queues and routine dispatch with axi4-lite registers
// Contract
// - no routine runs for an event before it is attached
// - many events may share a routine; one routine per event
// - attach also sets the event's own enable
// - while globally disabled, occurrences of attached events are queued
// - no routine starts while the global enable is clear
// - detach drops the association and clears the event enable
// - event numbers 0 to 33 with fixed source meanings
// - counter match, direction and reset events on their fixed numbers
// - pulse output 0 done is event 19, output 1 is 20
// - last routine instruction resumes the main program
// - conditional return with a true condition ends the routine early
// - save stack, accumulators and status on entry, restore on return
// - routine entry only at instruction boundaries
// - only one subroutine nesting level inside a routine
// - subroutine shares the routine's context, no extra save
// - entering run mode clears the global enable
// - a running routine is never pre-empted; new events wait
// - comm, io, timed queues of 8, 16, 8 with overflow flags
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "eaid_regs.svh"
module eaid_top import eaid_pkg::*; (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // axi4-lite write channels
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // axi4-lite read channels
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // on-chip event sources, one pulse bit per event number
  input wire logic [33:0] event_pulse_in,
  // program executor
  input wire logic run_entry_in,
  input wire logic insn_boundary_in,
  input wire logic routine_done_in,
  input wire logic cond_return_in,
  input wire logic cond_value_in,
  input wire logic sub_call_in,
  input wire logic sub_return_in,
  input wire logic forbidden_op_in,
  input wire logic [31:0] logic_stack_in,
  input wire logic [127:0] accum_in,
  input wire logic [7:0] acc_status_in,
  // dispatch and context restore
  output logic irq_start_out,
  output logic [6:0] irq_routine_out,
  output logic [5:0] irq_event_out,
  output logic in_routine_out,
  output logic resume_out,
  output logic [31:0] ctx_stack_out,
  output logic [127:0] ctx_accum_out,
  output logic [7:0] ctx_status_out,
  output logic op_error_out
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // lowest pending event of a mask, msb flags a hit
  function automatic logic [6:0] first_of(input logic [33:0] m);
    logic [6:0] r;
    r = '0;
    for (int i = `EAID_NUM_EV - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = {1'h1, 6'(i)};
      end
    end
    return r;
  endfunction
  function automatic logic [33:0] onehot(input logic [6:0] p);
    return p[6] ? (34'h1 << p[5:0]) : '0;
  endfunction
  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r, wdata_r;
  logic [7:0] waddr_r;
  logic [31:0] rd_word;
  logic rd_hit;
  wire aw_take = s_axi_awvalid_in && awready_r;
  wire w_take = s_axi_wvalid_in && wready_r;
  wire b_done = bvalid_r && s_axi_bready_in;
  wire ar_take = s_axi_arvalid_in && arready_r;
  // both halves held and no answer out yet: the write takes effect now
  wire wr_go = !awready_r && !wready_r && !bvalid_r;
  wire wr_ctrl = wr_go && (waddr_r == `EAID_OFS_CTRL);
  wire wr_att = wr_go && (waddr_r == `EAID_OFS_ATTACH);
  wire wr_det = wr_go && (waddr_r == `EAID_OFS_DETACH);
  wire wr_stat = wr_go && (waddr_r == `EAID_OFS_STATUS);
  wire wr_hit = wr_ctrl || wr_att || wr_det || wr_stat;
  wire [5:0] wr_ev = wdata_r[`EAID_EV_MSB:0];
  wire ev_ok = (wr_ev <= `EAID_LAST_EV);
  // channel handshakes; each ready drops on take and returns after b
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      awready_r <= 1'h1;
      wready_r <= 1'h1;
      bvalid_r <= 1'h0;
      bresp_r <= `EAID_RESP_OKAY;
      waddr_r <= '0;
      wdata_r <= '0;
    end else begin
      awready_r <= b_done || (awready_r && !aw_take);
      wready_r <= b_done || (wready_r && !w_take);
      bvalid_r <= wr_go || (bvalid_r && !s_axi_bready_in);
      bresp_r <= wr_go ? (wr_hit ? `EAID_RESP_OKAY : `EAID_RESP_SLVERR) : bresp_r;
      waddr_r <= aw_take ? s_axi_awaddr_in : waddr_r;
      wdata_r <= w_take ? s_axi_wdata_in : wdata_r;
    end
  end
  // read channel: one read at a time, unmapped answers slverr
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      arready_r <= 1'h1;
      rvalid_r <= 1'h0;
      rdata_r <= '0;
      rresp_r <= `EAID_RESP_OKAY;
    end else begin
      arready_r <= (rvalid_r && s_axi_rready_in) || (arready_r && !ar_take);
      rvalid_r <= ar_take || (rvalid_r && !s_axi_rready_in);
      rdata_r <= ar_take ? rd_word : rdata_r;
      rresp_r <= ar_take ? (rd_hit ? `EAID_RESP_OKAY : `EAID_RESP_SLVERR) : rresp_r;
    end
  end
  // ---------------------------------------------------------------
  // attach table
  // ---------------------------------------------------------------
  logic [33:0] en_r;
  eaid_rt_t route_r [`EAID_NUM_EV];
  // one route slot per event, so an event never has two routines
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      en_r <= '0;
      for (int i = 0; i < `EAID_NUM_EV; i++) begin
        route_r[i] <= '0;
      end
    end else if (wr_att && ev_ok) begin
      en_r[wr_ev] <= 1'h1;
      route_r[wr_ev] <= wdata_r[`EAID_RT_MSB:`EAID_RT_LSB];
    end else if (wr_det && ev_ok) begin
      en_r[wr_ev] <= 1'h0;
      route_r[wr_ev] <= '0;
    end
  end
  // ---------------------------------------------------------------
  // intake and queues
  // ---------------------------------------------------------------
  logic [33:0] pend_r;
  eaid_q_if qc();
  eaid_q_if qi();
  eaid_q_if qt();
  // unattached or disabled occurrences never reach a queue
  wire [33:0] accepted = event_pulse_in & en_r;
  // fixed source numbering decides the group; counters and pulses are io
  wire [33:0] io_mask = ~(`EAID_COMM_MASK | `EAID_TIMED_MASK);
  wire [6:0] pc = first_of(pend_r & `EAID_COMM_MASK);
  wire [6:0] pi = first_of(pend_r & io_mask);
  wire [6:0] pt = first_of(pend_r & `EAID_TIMED_MASK);
  // queueing goes on regardless of the global enable or a running routine
  assign qc.push = pc[6];
  assign qc.din = pc[5:0];
  assign qi.push = pi[6];
  assign qi.din = pi[5:0];
  assign qt.push = pt[6];
  assign qt.din = pt[5:0];
  // a repeat while still pending merges with the pending occurrence
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pend_r <= '0;
    end else begin
      pend_r <= (pend_r & ~(onehot(pc) | onehot(pi) | onehot(pt))) | accepted;
    end
  end
  eaid_queue #(.DEPTH(`EAID_COMM_DEPTH)) u_qc (.clk_in(clk_in), .rst_b_in(rst_b_in), .q(qc));
  eaid_queue #(.DEPTH(`EAID_IO_DEPTH)) u_qi (.clk_in(clk_in), .rst_b_in(rst_b_in), .q(qi));
  eaid_queue #(.DEPTH(`EAID_TIMED_DEPTH)) u_qt (.clk_in(clk_in), .rst_b_in(rst_b_in), .q(qt));
  // ---------------------------------------------------------------
  // dispatch
  // ---------------------------------------------------------------
  eaid_state_e state_r, state_nxt;
  logic gie_r, err_r, in_rt_r;
  wire any_ne = !(qc.empty && qi.empty && qt.empty);
  // gated by global enable, idle executor and an instruction boundary
  wire can_disp = gie_r && (state_r == ST_MAIN) && insn_boundary_in && any_ne;
  wire [5:0] pop_ev = !qc.empty ? qc.dout : (!qi.empty ? qi.dout : qt.dout);
  // an entry detached while queued is popped and dropped
  wire start_now = can_disp && en_r[pop_ev];
  assign qc.pop = can_disp && !qc.empty;
  assign qi.pop = can_disp && qc.empty && !qi.empty;
  assign qt.pop = can_disp && qc.empty && qi.empty;
  wire in_rt = (state_r != ST_MAIN);
  wire ret_now = in_rt && (routine_done_in || (cond_return_in && cond_value_in));
  // overflow flags are only meaningful until the queues drain
  wire ovf_clr = ret_now && !any_ne;
  assign qc.clear = ovf_clr;
  assign qi.clear = ovf_clr;
  assign qt.clear = ovf_clr;
  wire [2:0] ovf = {qt.ovf, qi.ovf, qc.ovf};
  wire sub_err = (state_r == ST_SUB) && sub_call_in;
  wire gie_bad = wr_ctrl && in_rt;
  wire err_set = sub_err || gie_bad || (forbidden_op_in && in_rt);
  wire err_clr = wr_stat && wdata_r[`EAID_ST_ERR_BIT];
  // executor state; a subroutine call saves nothing more
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_MAIN: if (start_now) state_nxt = ST_ROUTINE;
      ST_ROUTINE: begin
        if (ret_now) state_nxt = ST_MAIN;
        else if (sub_call_in) state_nxt = ST_SUB;
      end
      ST_SUB: begin
        if (ret_now) state_nxt = ST_MAIN;
        else if (sub_return_in) state_nxt = ST_ROUTINE;
      end
      default: state_nxt = ST_MAIN;
    endcase
  end
  // global enable writes inside a routine are refused; error set beats clear
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r <= ST_MAIN;
      gie_r <= 1'h0;
      err_r <= 1'h0;
    end else begin
      state_r <= state_nxt;
      gie_r <= run_entry_in ? 1'h0 : ((wr_ctrl && !in_rt) ? wdata_r[`EAID_GIE_BIT] : gie_r);
      err_r <= err_set || (err_r && !err_clr);
    end
  end
  // dispatch outputs and context held for the return
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_start_out <= 1'h0;
      irq_routine_out <= '0;
      irq_event_out <= '0;
      resume_out <= 1'h0;
      in_rt_r <= 1'h0;
      ctx_stack_out <= '0;
      ctx_accum_out <= '0;
      ctx_status_out <= '0;
    end else begin
      irq_start_out <= start_now;
      irq_routine_out <= start_now ? route_r[pop_ev] : irq_routine_out;
      irq_event_out <= start_now ? pop_ev : irq_event_out;
      resume_out <= ret_now;
      in_rt_r <= (state_nxt != ST_MAIN); // mirrors state_r so the port leaves a flop
      ctx_stack_out <= start_now ? logic_stack_in : ctx_stack_out;
      ctx_accum_out <= start_now ? accum_in : ctx_accum_out;
      ctx_status_out <= start_now ? acc_status_in : ctx_status_out;
    end
  end
  // ---------------------------------------------------------------
  // read decode and port drive
  // ---------------------------------------------------------------
  wire [7:0] ra = s_axi_araddr_in;
  wire [31:0] st_word = {10'h0, irq_event_out, 1'h0, irq_routine_out, 1'h0, ovf,
                         err_r, state_r == ST_SUB, in_rt, gie_r};
  assign rd_hit = (ra == `EAID_OFS_CTRL) || (ra == `EAID_OFS_STATUS);
  assign rd_word = (ra == `EAID_OFS_CTRL) ? {31'h0, gie_r} :
                   (ra == `EAID_OFS_STATUS) ? st_word : 32'h0;
  assign s_axi_awready_out = awready_r;
  assign s_axi_wready_out = wready_r;
  assign s_axi_bvalid_out = bvalid_r;
  assign s_axi_bresp_out = bresp_r;
  assign s_axi_arready_out = arready_r;
  assign s_axi_rvalid_out = rvalid_r;
  assign s_axi_rdata_out = rdata_r;
  assign s_axi_rresp_out = rresp_r;
  assign in_routine_out = in_rt_r;
  assign op_error_out = err_r;
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_start_needs_gie: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $rose(irq_start_out) |-> $past(gie_r)) else $error("routine started while disabled");
  a_start_attached: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    irq_start_out |-> (($past(en_r) >> irq_event_out) & 34'h1) == 34'h1)
    else $error("unattached event dispatched");
  a_attach_enables: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (wr_att && ev_ok) |=> en_r[$past(wr_ev)]) else $error("attach left event disabled");
  a_detach_clears: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (wr_det && ev_ok) |=> !en_r[$past(wr_ev)]) else $error("detach left event enabled");
  a_run_clears_gie: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    run_entry_in |=> !gie_r ##1 !irq_start_out) else $error("enable survived run entry");
  a_no_preempt: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    in_rt && !ret_now |=> !irq_start_out[*2]) else $error("routine pre-empted");
  a_return_resumes: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ret_now |=> resume_out && !in_routine_out) else $error("return did not resume");
  a_entry_boundary: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    irq_start_out |-> $past(insn_boundary_in)) else $error("entry off a boundary");
  a_sub_depth: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    sub_err |=> op_error_out && state_r == ST_SUB) else $error("second nesting accepted");
  a_ctx_saved: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    start_now |=> ctx_accum_out == $past(accum_in) && ctx_stack_out == $past(logic_stack_in))
    else $error("context not saved on entry");
  a_discard_off: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (event_pulse_in[0] && !en_r[0] && !pend_r[0]) |=> !pend_r[0]) else $error("disabled event kept");
endmodule

// file: eaid_exec_model.sv
// executor stand-in that runs each launched routine for a set number of cycles
`timescale 1ns/1ps
module eaid_exec_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // dispatch side
  input wire logic irq_start_in,
  input wire logic resume_in,
  input wire logic [7:0] hold_in,
  input wire logic auto_in,
  // executor outputs
  output logic boundary_out,
  output logic done_out
);
  logic [1:0] ph_r;
  logic [7:0] cnt_r;
  logic busy_r;
  // one cycle in four is mid-instruction, so entry has to wait for it
  assign boundary_out = (ph_r != 2'h3);
  // routine body: never tries counter define or end, the bench commands those
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ph_r <= 2'h0;
      cnt_r <= 8'h00;
      busy_r <= 1'b0;
      done_out <= 1'b0;
    end else begin
      ph_r <= ph_r + 2'h1;
      done_out <= 1'b0;
      if (irq_start_in) begin
        busy_r <= 1'b1;
        cnt_r <= hold_in;
      end else if (resume_in) begin
        busy_r <= 1'b0;
      end else if (busy_r && cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end else if (busy_r && auto_in) begin
        // last instruction finished, hand control back
        busy_r <= 1'b0;
        done_out <= 1'b1;
      end
    end
  end
endmodule

// file: event_attach_interrupt_dispatch_test.sv
// self-checking bench for the event attach and dispatch block
`timescale 1ns/1ps
`include "eaid_regs.svh"
module event_attach_interrupt_dispatch_test import eaid_pkg::*;;
  logic clk_in, rst_b_in = 0;
  logic [7:0] awaddr = 0, araddr = 0, hold = 8'h04;
  logic [31:0] wdata = 0, rdata, stack, cstack;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, boundary, done, start, in_rt, resume;
  logic [1:0] bresp, rresp;
  logic [33:0] ev_pulse = 0;
  logic run_entry = 0, cond_ret = 0, cond_val = 0, sub_call = 0, auto_done = 1;
  logic sub_ret = 0, forbid = 0, err_o;
  logic [127:0] accum, caccum;
  logic [7:0] status, cstatus;
  logic [6:0] rt_o;
  logic [5:0] ev_o;
  logic [167:0] ctx_held;
  logic [12:0] exp_q[$];
  logic gie_m = 0, busy_m = 0, ctx_pend = 0;
  int rt_m[34];
  int errors = 0, checks = 0, cyc = 0;

  eaid_top dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .event_pulse_in(ev_pulse),
    .run_entry_in(run_entry), .insn_boundary_in(boundary), .routine_done_in(done),
    .cond_return_in(cond_ret), .cond_value_in(cond_val), .sub_call_in(sub_call),
    .sub_return_in(sub_ret), .forbidden_op_in(forbid), .logic_stack_in(stack),
    .accum_in(accum), .acc_status_in(status), .irq_start_out(start),
    .irq_routine_out(rt_o), .irq_event_out(ev_o), .in_routine_out(in_rt),
    .resume_out(resume), .ctx_stack_out(cstack), .ctx_accum_out(caccum),
    .ctx_status_out(cstatus), .op_error_out(err_o));
  eaid_exec_model partner (.clk_in(clk_in), .rst_b_in(rst_b_in), .irq_start_in(start),
    .resume_in(resume), .hold_in(hold), .auto_in(auto_done), .boundary_out(boundary),
    .done_out(done));

  // ---------------------------------------------------------------
  // clock, timeout and verdict
  // ---------------------------------------------------------------
  initial begin
    clk_in = 0;
    forever #4 clk_in = ~clk_in;
  end
  task automatic wrap_up();
    if (errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [167:0] seen, input logic [167:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // ---------------------------------------------------------------
  // bus master and stimulus tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge clk_in);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    // bready stays up between writes, so no step lowers and raises it at once
    chk("bresp", bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, em, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge clk_in);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    // rready stays up between reads for the same reason
    chk("rdata", rdata & em, ed);
    chk("rresp", rresp, er);
  endtask
  task automatic att(input int e, input int t);
    wr(`EAID_OFS_ATTACH, {17'h0, t[6:0], 2'h0, e[5:0]}, 2'h0);
    rt_m[e] = t;
  endtask
  task automatic setg(input logic g);
    wr(`EAID_OFS_CTRL, {31'h0, g}, 2'h0);
    gie_m = g;
  endtask
  // one occurrence, spaced so that repeats never merge while pending
  task automatic fire(input int e);
    ev_pulse <= 34'h1 << e;
    hold <= 8'($urandom_range(9, 2));
    @(posedge clk_in);
    ev_pulse <= '0;
    if (rt_m[e] >= 0) exp_q.push_back({e[5:0], rt_m[e][6:0]});
    repeat (2) @(posedge clk_in);
  endtask
  task automatic xpulse(input logic [2:0] m);
    {run_entry, sub_call, cond_ret} <= m;
    @(posedge clk_in);
    {run_entry, sub_call, cond_ret} <= 3'h0;
    repeat (3) @(posedge clk_in);
  endtask
  task automatic wait_idle();
    while (exp_q.size() != 0 || busy_m) @(posedge clk_in);
  endtask

  // ---------------------------------------------------------------
  // reference model checked at every launch and return
  // ---------------------------------------------------------------
  always @(posedge clk_in) begin
    if (ctx_pend) begin
      chk("saved context", {cstack, caccum, cstatus}, ctx_held);
      ctx_pend = 0;
      stack <= $urandom;
      accum <= {$urandom, $urandom, $urandom, $urandom};
      status <= 8'($urandom);
    end
    if (resume) begin
      chk("restored context", {cstack, caccum, cstatus}, ctx_held);
      busy_m = 0;
    end
    if (start) begin
      chk("launch allowed", {gie_m, busy_m, exp_q.size() != 0}, 3'h5);
      if (exp_q.size() != 0) chk("launch", {ev_o, rt_o}, exp_q.pop_front());
      busy_m = 1;
      ctx_pend = 1;
      ctx_held = {stack, accum, status};
    end
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h7f95));
    stack = $urandom;
    accum = {$urandom, $urandom, $urandom, $urandom};
    status = 8'($urandom);
    foreach (rt_m[i]) rt_m[i] = -1;
    repeat (12) @(posedge clk_in);
    rst_b_in <= 1;
    rd(`EAID_OFS_CTRL, 32'h0, 32'h1, 2'h0);
    rd(`EAID_OFS_ATTACH, 32'h0, 32'h0, 2'h2);
    rd(8'h10, 32'h0, 32'h0, 2'h2);
    wr(8'h20, 32'h1, 2'h2);
    // queued while disabled, serviced in arrival order once enabled
    att(12, 5);
    att(19, 7);
    att(20, 7);
    att(19, 9);
    fire(12);
    fire(19);
    fire(3);
    repeat (20) @(posedge clk_in);
    setg(1);
    wait_idle();
    wr(`EAID_OFS_DETACH, 32'h14, 2'h0);
    rt_m[20] = -1;
    fire(20);
    repeat (20) @(posedge clk_in);
    // every event number with a random routine
    for (int e = 0; e < 34; e++) begin
      att(e, $urandom_range(127));
      fire(e);
      wait_idle();
    end
    // early return, subroutine depth and the error it raises
    auto_done <= 0;
    fire(5);
    while (!busy_m) @(posedge clk_in);
    xpulse(3'h1);
    chk("false return ignored", in_rt, 1'b1);
    xpulse(3'h2);
    rd(`EAID_OFS_STATUS, {10'h0, 6'h05, 1'b0, rt_m[5][6:0], 8'h07}, 32'h3F7F0F, 2'h0);
    sub_ret <= 1;
    @(posedge clk_in);
    sub_ret <= 0;
    rd(`EAID_OFS_STATUS, 32'h3, 32'h7, 2'h0);
    xpulse(3'h2);
    xpulse(3'h2);
    rd(`EAID_OFS_STATUS, {28'h0, 4'hF}, 32'hF, 2'h0);
    chk("error flag", err_o, 1'b1);
    wr(`EAID_OFS_STATUS, 32'h8, 2'h0);
    chk("error cleared", err_o, 1'b0);
    // a forbidden operation inside the routine raises the error again
    forbid <= 1;
    @(posedge clk_in);
    forbid <= 0;
    @(posedge clk_in);
    chk("forbidden op", err_o, 1'b1);
    wr(`EAID_OFS_STATUS, 32'h8, 2'h0);
    // a global off inside the routine is refused and flagged
    wr(`EAID_OFS_CTRL, 32'h0, 2'h0);
    rd(`EAID_OFS_STATUS, 32'h9, 32'h9, 2'h0);
    cond_val <= 1;
    xpulse(3'h1);
    wait_idle();
    auto_done <= 1;
    // io queue overflow while disabled, flag cleared after draining
    setg(0);
    for (int i = 0; i < 18; i++) fire(0);
    while (exp_q.size() > 16) void'(exp_q.pop_back());
    rd(`EAID_OFS_STATUS, 32'h20, 32'h70, 2'h0);
    setg(1);
    wait_idle();
    rd(`EAID_OFS_STATUS, 32'h0, 32'h70, 2'h0);
    // entering run mode closes the gate again
    xpulse(3'h4);
    gie_m = 0;
    rd(`EAID_OFS_CTRL, 32'h0, 32'h1, 2'h0);
    fire(12);
    repeat (20) @(posedge clk_in);
    setg(1);
    wait_idle();
    wrap_up();
  end
endmodule
